// ==== eewt_pkg.sv ====
// Constants, widths and state codes of the two-wire serial memory slave.
// Assumes a 50 MHz system clock and a two-wire bus with pull-ups outside.
//
// Contract
// - Nonvolatile array of 4096 bytes, reached over the two-wire slave port.
// - Each program cycle is self-timed and erases target bytes before writing.
// - Page write takes up to 32 data bytes, programmed in one cycle.
// - Every location reads FF before it is first written.
// - Clock and data spikes of 0.1 us or less are filtered out.
// - Incoming data bits are captured on the clock's rising edge.
// - Driven data changes only after a clock falling edge.
// - Write protect high before the cycle starts cancels the write.
// - Write protect high during the cycle aborts it; bytes are undefined.
// - START is data falling while clock high; detected at any time.
// - All bus activity is ignored until a START is seen.
// - STOP is data rising while clock high; device returns to idle.
// - Address byte is 1010, 000, then direction; only it is answered.
// - Program cycle starts only on STOP after a write; else data dropped.
// - Low five address bits step and wrap after each byte; upper seven hold. Reads instead step all 12 bits.

package eewt_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned SPIKE_NS = 100;
  localparam int unsigned SPIKE_CYC = (SPIKE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PROG_TIME_US = 5000;
  localparam int unsigned PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned MEM_DEPTH = 4096;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned OFF_W = 5;
  localparam int unsigned PAGE_W = 7;
  localparam int unsigned PAGE_BYTES = 32;
  localparam int unsigned PCNT_W = 18;
  localparam int unsigned FCNT_W = 3;
  localparam logic [FCNT_W-1:0] SPIKE_LIM = FCNT_W'(SPIKE_CYC);
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam logic [2:0] DEV_SEL = 3'h0;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic LINE_RST = 1'h1;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_RX = 8'h02,
    S_RXEND = 8'h04,
    S_ACK = 8'h08,
    S_TX = 8'h10,
    S_MACK = 8'h20,
    S_MACKD = 8'h40,
    S_IGN = 8'h80
  } eewt_state_t;

  typedef enum logic [3:0] {
    R_DEV = 4'h1,
    R_AHI = 4'h2,
    R_ALO = 4'h4,
    R_DAT = 4'h8
  } eewt_role_t;
endpackage : eewt_pkg

// ==== eewt_line_if.sv ====
// Filtered bus levels and the synchronised, unfiltered write-protect level passed from the input filter.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface eewt_line_if;
  logic scl;
  logic sda;
  logic wp;
  modport filt (output scl, sda, wp);
  modport core (input scl, sda, wp);
endinterface : eewt_line_if
`default_nettype wire

// ==== eewt_filter.sv ====
// Synchronises the bus pins and write protect, and removes short spikes.
// Assumes pins are asynchronous to clk; bus lines idle high.
`timescale 1ns/1ps
`default_nettype none
module eewt_filter
  import eewt_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Raw pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic wp_pin,
  // Cleaned levels
  eewt_line_if.filt lines
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [1:0] lvl;
    logic [1:0][FCNT_W-1:0] cnt;
  } eewt_filt_t;

  eewt_filt_t q;
  eewt_filt_t n;

  always_comb begin
    n = q;
    n.s1 = {wp_pin, sda_pin, scl_pin};
    n.s2 = q.s1;
    for (int i = 0; i < 2; i++) begin
      if (q.s2[i] == q.lvl[i]) begin
        n.cnt[i] = '0;
      end else if (q.cnt[i] == SPIKE_LIM) begin
        n.lvl[i] = q.s2[i];
        n.cnt[i] = '0;
      end else begin
        n.cnt[i] = q.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.s1 <= {3{LINE_RST}};
      q.s2 <= {3{LINE_RST}};
      q.lvl <= {2{LINE_RST}};
    end else begin
      q <= n;
    end
  end

  assign lines.scl = q.lvl[0];
  assign lines.sda = q.lvl[1];
  assign lines.wp = q.s2[2];
endmodule : eewt_filter
`default_nettype wire

// ==== eewt_slave.sv ====
// Two-wire serial memory slave: 4096 bytes, 32-byte page programming,
// self-timed erase-then-write cycle and write-protect cancel and abort.
// Assumes an external pull-up on the data line and that a master drives
// the bus clock; the system clock oversamples both bus lines.
`timescale 1ns/1ps
`default_nettype none
module eewt_slave
  import eewt_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC
) (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Two-wire bus
  input wire logic scl_pin,
  input wire logic sda_in,
  output var logic sda_out,
  output var logic sda_oe,
  // Write protect
  input wire logic wp_pin,
  // Status
  output var logic prog_busy
);
  typedef struct packed {
    eewt_state_t st;
    eewt_role_t role;
    logic [2:0] bits;
    logic [7:0] shf;
    logic rd;
    logic ackp;
    logic oe;
    logic [ADDR_W-1:0] addr;
    logic [PAGE_W-1:0] page;
    logic [OFF_W-1:0] woff;
    logic [PAGE_BYTES-1:0] mask;
    logic have;
    logic cancel;
    logic busy;
    logic [PCNT_W-1:0] pcnt;
    logic scl_q;
    logic sda_q;
  } eewt_core_t;

  localparam logic [PCNT_W-1:0] PG_END = PCNT_W'(PROG_CYCLES - 1);
  localparam logic [PCNT_W-1:0] WR_BASE = PCNT_W'(PROG_CYCLES - PAGE_BYTES);
  localparam logic [PCNT_W-1:0] ER_END = PCNT_W'(PAGE_BYTES);

  eewt_line_if lines ();

  eewt_filter u_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .scl_pin(scl_pin),
    .sda_pin(sda_in),
    .wp_pin(wp_pin),
    .lines(lines)
  );

  eewt_core_t q;
  eewt_core_t n;

  logic [7:0] mem_ar [0:MEM_DEPTH-1];
  logic [7:0] buf_ar [0:PAGE_BYTES-1];

  initial begin
    for (int i = 0; i < MEM_DEPTH; i++) begin
      mem_ar[i] = ERASED;
    end
  end

  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [7:0] rbyte;
  logic [7:0] mem_rd;
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic buf_we;
  logic [OFF_W-1:0] buf_wa;
  logic [7:0] buf_wd;

  assign rise = lines.scl & ~q.scl_q;
  assign fall = ~lines.scl & q.scl_q;
  assign start = lines.scl & q.scl_q & q.sda_q & ~lines.sda;
  assign stop = lines.scl & q.scl_q & ~q.sda_q & lines.sda;
  assign rbyte = {q.shf[6:0], lines.sda};
  assign mem_rd = mem_ar[q.addr];

  always_comb begin
    logic [OFF_W-1:0] idx;
    logic do_load;
    idx = '0;
    do_load = 1'b0;
    n = q;
    n.scl_q = lines.scl;
    n.sda_q = lines.sda;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = ERASED;
    buf_we = 1'b0;
    buf_wa = q.woff;
    buf_wd = rbyte;

    if (q.busy) begin
      n.pcnt = q.pcnt + 1'b1;
      if (lines.wp) begin
        // abort on protect
        // Bytes already erased stay erased until rewritten; the page is left undefined.
        n.busy = 1'b0;
      end else begin
        if (q.pcnt < ER_END) begin
          idx = q.pcnt[OFF_W-1:0];
          mem_we = q.mask[idx];
          mem_wa = {q.page, idx};
          mem_wd = ERASED;
        end else if (q.pcnt >= WR_BASE) begin
          idx = q.pcnt[OFF_W-1:0] - WR_BASE[OFF_W-1:0];
          mem_we = q.mask[idx];
          mem_wa = {q.page, idx};
          mem_wd = buf_ar[idx];
        end
        if (q.pcnt == PG_END) begin
          n.busy = 1'b0;
        end
      end
    end

    if (start) begin
      n.st = S_RX;
      n.role = R_DEV;
      n.bits = '0;
      n.oe = 1'b0;
      n.have = 1'b0;
    end else if (stop) begin
      n.st = S_IDLE;
      n.oe = 1'b0;
      n.have = 1'b0;
      if (q.have & ~q.cancel & ~lines.wp & ~q.busy) begin
        n.busy = 1'b1;
        n.pcnt = '0;
      end
    end else begin
      unique case (q.st)
        S_IDLE: begin
        end
        S_RX: begin
          if (rise) begin
            n.shf = rbyte;
            n.bits = q.bits + 1'b1;
            if (q.bits == LAST_BIT) begin
              n.st = S_RXEND;
              n.ackp = 1'b1;
              unique case (q.role)
                R_DEV: begin
                  n.ackp = (rbyte[7:1] == {DEV_TYPE, DEV_SEL}) & ~q.busy;
                  n.rd = rbyte[0];
                  n.role = rbyte[0] ? R_DAT : R_AHI;
                end
                R_AHI: begin
                  n.addr[ADDR_W-1:8] = rbyte[3:0];
                  n.role = R_ALO;
                end
                R_ALO: begin
                  n.addr = {q.addr[ADDR_W-1:8], rbyte};
                  n.page = {q.addr[ADDR_W-1:8], rbyte[7:5]};
                  n.woff = rbyte[OFF_W-1:0];
                  n.mask = '0;
                  n.cancel = 1'b0;
                  n.role = R_DAT;
                end
                R_DAT: begin
                  buf_we = 1'b1;
                  n.mask[q.woff] = 1'b1;
                  n.addr = {q.page, q.woff};
                  n.woff = q.woff + 1'b1;
                  n.have = 1'b1;
                  n.cancel = q.have ? (q.cancel | lines.wp) : lines.wp;
                end
                default: begin
                  n.st = S_IGN;
                end
              endcase
            end
          end
        end
        S_RXEND: begin
          if (fall) begin
            n.oe = q.ackp;
            n.st = q.ackp ? S_ACK : S_IGN;
          end
        end
        S_ACK: begin
          if (fall) begin
            n.bits = '0;
            if (q.rd) begin
              do_load = 1'b1;
            end else begin
              n.oe = 1'b0;
              n.st = S_RX;
            end
          end
        end
        S_TX: begin
          if (fall) begin
            if (q.bits == LAST_BIT) begin
              n.oe = 1'b0;
              n.st = S_MACK;
            end else begin
              n.shf = {q.shf[6:0], 1'b0};
              n.oe = ~q.shf[6];
              n.bits = q.bits + 1'b1;
            end
          end
        end
        S_MACK: begin
          if (rise) begin
            n.st = lines.sda ? S_IGN : S_MACKD;
          end
        end
        S_MACKD: begin
          if (fall) begin
            n.bits = '0;
            do_load = 1'b1;
          end
        end
        S_IGN: begin
        end
        default: begin
          n.st = S_IDLE;
          n.oe = 1'b0;
        end
      endcase
    end

    // The array walks on across the whole address space during reads.
    if (do_load) begin
      n.shf = mem_rd;
      n.oe = ~mem_rd[7];
      n.addr = q.addr + 1'b1;
      n.st = S_TX;
    end

    if (q.have & lines.wp) begin
      n.cancel = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= S_IDLE;
      q.role <= R_DEV;
      q.scl_q <= LINE_RST;
      q.sda_q <= LINE_RST;
    end else begin
      q <= n;
    end
  end

  // Kept across reset; a plain always lets the factory fill share the array.
  always @(posedge clk) begin
    if (mem_we) begin
      mem_ar[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge clk) begin
    if (buf_we) begin
      buf_ar[buf_wa] <= buf_wd;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = q.oe;
  assign prog_busy = q.busy;
endmodule : eewt_slave
`default_nettype wire

// ==== eewt_slave_asserts.sv ====
// Port-level checks of the two-wire memory slave.
// Assumes a pulled-up data wire seen on sda_in and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module eewt_slave_chk
  import eewt_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC
) (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Bus and status
  input wire logic scl_pin,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic wp_pin,
  input wire logic prog_busy
);
  logic [19:0] cnt_ff;
  logic ab_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Busy length and abort seen are counted to judge the full cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= 20'h00000;
      ab_ff <= 1'b0;
    end else begin
      cnt_ff <= prog_busy ? cnt_ff + 20'h00001 : 20'h00000;
      ab_ff <= prog_busy ? (ab_ff | wp_pin) : 1'b0;
    end
  end
  property p_low_only; sda_out == 1'b0; endproperty
  a_low_only: assert property (p_low_only)
    else $error("data output driven high");
  property p_busy_quiet; prog_busy |-> !sda_oe; endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("data pulled low while programming");
  property p_abort; prog_busy && wp_pin |-> ##[1:4] !prog_busy; endproperty
  a_abort: assert property (p_abort)
    else $error("program cycle not aborted by write protect");
  property p_length;
    $fell(prog_busy) && !ab_ff |-> cnt_ff == 20'(PROG_CYCLES);
  endproperty
  a_length: assert property (p_length)
    else $error("program cycle length wrong");
  property p_after_stop; $rose(prog_busy) |-> scl_pin && sda_in; endproperty
  a_after_stop: assert property (p_after_stop)
    else $error("program cycle began without a stop");
  property p_wp_block; $rose(prog_busy) |-> !wp_pin; endproperty
  a_wp_block: assert property (p_wp_block)
    else $error("program cycle began under write protect");
  property p_stable_high;
    scl_pin && $past(scl_pin) |-> $stable(sda_oe);
  endproperty
  a_stable_high: assert property (p_stable_high)
    else $error("data changed while clock high");
  property p_late_change;
    $rose(sda_oe) |-> !scl_pin && !$past(scl_pin, 4) && !$past(scl_pin, 8);
  endproperty
  a_late_change: assert property (p_late_change)
    else $error("data pulled low too soon after clock fall");
endmodule : eewt_slave_chk
bind eewt_slave eewt_slave_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clk(clk), .sda_in(sda_in), .sys_rst(sys_rst), .scl_pin(scl_pin),
  .sda_out(sda_out), .sda_oe(sda_oe), .wp_pin(wp_pin),
  .prog_busy(prog_busy));
`default_nettype wire

// ==== eewt_master.sv ====
// Behavioural two-wire bus master; the bench calls its tasks.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module eewt_master (
  // System
  input wire logic clk,
  // Bus
  input wire logic sda,
  output var logic scl,
  output var logic oe
);
  initial begin
    scl = 1'b1;
    oe = 1'b0;
  end
  task qtr;
    repeat (8) @(posedge clk);
  endtask : qtr
  task bit_out(input logic b, output logic s);
    oe <= ~b;
    qtr();
    scl <= 1'b1;
    qtr();
    @(negedge clk) s = sda;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask : bit_out
  task wbyte(input logic [7:0] b, output logic nk);
    logic s;
    for (int i = 7; i >= 0; i--) bit_out(b[i], s);
    bit_out(1'b1, nk);
  endtask : wbyte
  task rbyte(output logic [7:0] d, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) bit_out(1'b1, d[i]);
    bit_out(last, s);
  endtask : rbyte
  // short clock pulse, after the data line has settled.
  task spike(input int len);
    qtr();
    scl <= 1'b1;
    repeat (len) @(posedge clk);
    scl <= 1'b0;
    qtr();
  endtask : spike
  task start;
    oe <= 1'b0;
    qtr();
    scl <= 1'b1;
    qtr();
    oe <= 1'b1;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask : start
  task stop;
    oe <= 1'b1;
    qtr();
    scl <= 1'b1;
    qtr();
    oe <= 1'b0;
    qtr();
    qtr();
  endtask : stop
endmodule : eewt_master
`default_nettype wire

// ==== eewt_slave_bench.sv ====
// Self-checking bench of the two-wire memory slave with a master model.
// Assumes a pull-up on the data wire; program cycle shortened to 600.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  err_count++; $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module eewt_slave_bench;
  import eewt_pkg::*;
  logic clk, sys_rst, wp_pin, sda_oe, sda_out, prog_busy, scl_pin, m_oe;
  logic nk;
  int err_count = 0;
  int total_checks = 0;
  wire logic sda_w = ~(m_oe | sda_oe);
  eewt_slave #(.PROG_CYCLES(600)) uut (.clk(clk), .sys_rst(sys_rst),
    .scl_pin(scl_pin), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .wp_pin(wp_pin), .prog_busy(prog_busy));
  eewt_master m (.clk(clk), .sda(sda_w), .scl(scl_pin), .oe(m_oe));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task stop_test;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task wb(input logic [7:0] b);
    m.wbyte(b, nk);
    `CHK(nk, 1'b0)
  endtask : wb
  task cmd(input logic [11:0] a);
    m.start();
    wb(8'hA0);
    wb({4'h0, a[11:8]});
    wb(a[7:0]);
  endtask : cmd
  task rd2(input logic [11:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] d;
    cmd(a);
    m.start();
    wb(8'hA1);
    m.rbyte(d, 1'b0);
    `CHK(d, e0)
    m.rbyte(d, 1'b1);
    `CHK(d, e1)
    m.stop();
  endtask : rd2
  task wbusy;
    int i;
    repeat (4) @(posedge clk);
    for (i = 0; i < 1000 && prog_busy !== 1'b0; i++) @(posedge clk);
    if (i == 1000) begin
      err_count++;
      stop_test();
    end
  endtask : wbusy
  task t_idle;
    m.wbyte(8'hA0, nk);
    `CHK(nk, 1'b1)
    m.start();
    m.wbyte(8'hA2, nk);
    `CHK(nk, 1'b1)
    m.stop();
    rd2(12'h123, ERASED, ERASED);
    $display("test idle done");
  endtask : t_idle
  task t_page;
    cmd(12'h05F);
    wb(8'h11);
    wb(8'h22);
    wb(8'h33);
    m.stop();
    `CHK(prog_busy, 1'b1)
    m.start();
    m.wbyte(8'hA0, nk);
    `CHK(nk, 1'b1)
    m.stop();
    wbusy();
    rd2(12'h040, 8'h22, 8'h33);
    rd2(12'h05F, 8'h11, ERASED);
    $display("test page done");
  endtask : t_page
  task t_nostop;
    cmd(12'h200);
    wb(8'h77);
    cmd(12'h201);
    m.stop();
    `CHK(prog_busy, 1'b0)
    rd2(12'h200, ERASED, ERASED);
    $display("test nostop done");
  endtask : t_nostop
  task t_spike;
    cmd(12'h300);
    m.spike(SPIKE_CYC);
    wb(8'h5A);
    m.stop();
    wbusy();
    rd2(12'h300, 8'h5A, ERASED);
    $display("test spike done");
  endtask : t_spike
  task t_cancel;
    cmd(12'h100);
    wb(8'h12);
    wp_pin <= 1'b1;
    repeat (60) @(posedge clk);
    wp_pin <= 1'b0;
    m.stop();
    `CHK(prog_busy, 1'b0)
    rd2(12'h100, ERASED, ERASED);
    $display("test cancel done");
  endtask : t_cancel
  task t_abort;
    cmd(12'h040);
    wb(8'h55);
    m.stop();
    repeat (40) @(posedge clk);
    wp_pin <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK(prog_busy, 1'b0)
    wp_pin <= 1'b0;
    rd2(12'h040, ERASED, 8'h33);
    $display("test abort done");
  endtask : t_abort
  initial begin
    sys_rst = 1'b1;
    wp_pin = 1'b0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk);
    t_idle();
    t_page();
    t_nostop();
    t_spike();
    t_cancel();
    t_abort();
    stop_test();
  end
endmodule : eewt_slave_bench
`default_nettype wire
